// [hdl/qws_defines.svh]
// constants for the four-channel wiper serial slave
// assumes a 50 MHz ref_clk; pins arrive asynchronous to it
`ifndef QWS_DEFINES_SVH
`define QWS_DEFINES_SVH

`define QWS_CLK_KHZ 50000
`define QWS_NV_WRITE_MS 5
`define QWS_NV_WRITE_CYCLES (`QWS_NV_WRITE_MS * `QWS_CLK_KHZ)
`define QWS_NV_RESET_VALUE 8'h80

`define QWS_CHANNELS 4
`define QWS_SLOTS 4

// instruction byte layout
`define QWS_OP_MSB 7
`define QWS_OP_LSB 4
`define QWS_ADDR_MSB 3
`define QWS_ADDR_LSB 2
`define QWS_CHAN_MSB 1
`define QWS_CHAN_LSB 0
// argument byte layout
`define QWS_ARG_DIR_BIT 7
`define QWS_ARG_SLOT_MSB 1
`define QWS_ARG_SLOT_LSB 0

// operation codes
`define QWS_OP_RD_WIPER 4'h9
`define QWS_OP_WR_WIPER 4'ha
`define QWS_OP_RD_SLOT 4'hb
`define QWS_OP_WR_SLOT 4'hc
`define QWS_OP_XFER 4'hd
`define QWS_OP_INCDEC 4'h2

// synchroniser vector {sck, cs_n, si, hold_n, wp_n, a1, a0}
`define QWS_SYNC_RST 7'h2c
`define QWS_SYNC_SCK 6
`define QWS_SYNC_CS 5
`define QWS_SYNC_SI 4
`define QWS_SYNC_HOLD 3
`define QWS_SYNC_WP 2

`endif

// [hdl/qws_pkg.sv]
// types shared by the wiper serial slave files
// no assumptions beyond the defines header
package qws_pkg;
  typedef enum logic [2:0] {
    QWS_ST_IDLE,
    QWS_ST_OPC,
    QWS_ST_ARG,
    QWS_ST_DATA,
    QWS_ST_READ,
    QWS_ST_INCDEC,
    QWS_ST_DONE
  } qws_state_e;
endpackage

// [hdl/qws_nv_store.sv]
// non-volatile setting slots with a timed write cycle
// assumes wr_start arrives only while busy is low
`timescale 1ns/1ns
`include "qws_defines.svh"

module qws_nv_store
  import qws_pkg::*;
#(
  parameter int WRITE_CYCLES = `QWS_NV_WRITE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wr_start,
  input wire logic [3:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_index,
  output logic [7:0] rd_data,
  output logic [31:0] boot_data,
  output logic busy
);
  logic [7:0] nonvolatile_setting_slot [0:15];
  logic [31:0] cnt_q;
  logic [3:0] idx_q;
  logic [7:0] data_q;

  assign rd_data = nonvolatile_setting_slot[rd_index];

  genvar g;
  generate
    for (g = 0; g < `QWS_CHANNELS; g++)
    begin : g_boot
      // slot zero of each channel is the boot setting slot
      assign boot_data[g*8 +: 8] = nonvolatile_setting_slot[g*4];
    end
  endgenerate

  // write runs to the end once started, whatever wp does
  // write always completes
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      busy <= 1'b0;
      cnt_q <= 32'h0;
      idx_q <= 4'h0;
      data_q <= 8'h00;
    end
    else if (wr_start && !busy)
    begin
      busy <= 1'b1;
      cnt_q <= 32'(WRITE_CYCLES);
      idx_q <= wr_index;
      data_q <= wr_data;
    end
    else if (busy)
    begin
      cnt_q <= cnt_q - 32'h1;
      if (cnt_q <= 32'h1)
        busy <= 1'b0;
    end
  end

  // sys_rst stands in for power-up; cells commit at cycle end
  // four slots per channel
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 16; i++)
        nonvolatile_setting_slot[i] <= `QWS_NV_RESET_VALUE;
    end
    else if (busy && cnt_q <= 32'h1)
      nonvolatile_setting_slot[idx_q] <= data_q;
  end
endmodule

// [hdl/qws_serial_slave.sv]
// serial slave front end for four volatile wipers and their slots
// assumes all serial pins and straps are asynchronous to ref_clk
`timescale 1ns/1ns
`include "qws_defines.svh"

// Function
// - sample serial input on clock rise
// - shift read data out on falling edge
// - act only when address matches straps
// - select high: output off, standby
// - slot write starts at select rise
// - write protect blocks slot writes only
// - protect fall mid-frame drops pending write
// - started slot write always completes
// - hold fall while sck low pauses: output off, input ignored
// - first byte loads instruction register
// - six operation codes select operation
// - per channel wiper plus four slots
// - boot slot copied to wiper at power-up
// - transfers and increment/decrement mode
module qws_serial_slave
  import qws_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `QWS_NV_WRITE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic strap_addr_bit_low,
  input wire logic strap_addr_bit_high,
  output logic spi_so,
  output logic spi_so_oe,
  output logic [31:0] wiper_setting_reg,
  output logic nv_busy
);
  function automatic logic op_known(input logic [3:0] op);
    case (op)
      `QWS_OP_RD_WIPER, `QWS_OP_WR_WIPER, `QWS_OP_RD_SLOT,
      `QWS_OP_WR_SLOT, `QWS_OP_XFER, `QWS_OP_INCDEC:
        op_known = 1'b1;
      default:
        op_known = 1'b0;
    endcase
  endfunction

  logic [6:0] s1_q, s2_q, s3_q;
  qws_state_e st_q;
  logic [7:0] sh_q, instr_q, out_q, pend_data_q, nv_rd_data;
  logic [2:0] bit_q;
  logic [1:0] slot_q, chan;
  logic paused_q, pend_q, boot_q;
  logic [3:0] pend_idx_q, op, rd_index;
  logic [31:0] nv_boot_data;
  logic [7:0] rx_byte;
  logic sck, cs_n, si, wp;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  logic wp_fall, hold_fall, hold_rise;
  logic active, shift_en, byte_done, nv_start;

  // two stages before any logic; edges compare stage two to three
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      {s1_q, s2_q, s3_q} <= {3{`QWS_SYNC_RST}};
    else
    begin
      s1_q <= {spi_sck, spi_cs_n, spi_si, hold_n, wp_n,
               strap_addr_bit_high, strap_addr_bit_low};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sck = s2_q[`QWS_SYNC_SCK];
  assign cs_n = s2_q[`QWS_SYNC_CS];
  assign si = s2_q[`QWS_SYNC_SI];
  assign wp = s2_q[`QWS_SYNC_WP];
  assign sck_rise = sck && !s3_q[`QWS_SYNC_SCK];
  assign sck_fall = !sck && s3_q[`QWS_SYNC_SCK];
  assign cs_fall = !cs_n && s3_q[`QWS_SYNC_CS];
  assign cs_rise = cs_n && !s3_q[`QWS_SYNC_CS];
  assign wp_fall = !wp && s3_q[`QWS_SYNC_WP];
  assign hold_fall = !s2_q[`QWS_SYNC_HOLD] && s3_q[`QWS_SYNC_HOLD];
  assign hold_rise = s2_q[`QWS_SYNC_HOLD] && !s3_q[`QWS_SYNC_HOLD];
  assign active = !cs_n && !paused_q;
  assign shift_en = sck_rise && active && st_q != QWS_ST_IDLE &&
                    st_q != QWS_ST_DONE;
  assign byte_done = shift_en && bit_q == 3'h7;
  assign rx_byte = {sh_q[6:0], si};
  assign op = (st_q == QWS_ST_OPC) ?
              rx_byte[`QWS_OP_MSB:`QWS_OP_LSB] :
              instr_q[`QWS_OP_MSB:`QWS_OP_LSB];
  assign chan = (st_q == QWS_ST_OPC) ?
                rx_byte[`QWS_CHAN_MSB:`QWS_CHAN_LSB] :
                instr_q[`QWS_CHAN_MSB:`QWS_CHAN_LSB];
  assign rd_index = {chan, rx_byte[`QWS_ARG_SLOT_MSB:`QWS_ARG_SLOT_LSB]};
  assign nv_start = cs_rise && pend_q && wp;

  // pause and resume are only taken while sck is low
  // pause on hold fall
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || cs_n)
      paused_q <= 1'b0;
    else if (hold_fall && !sck)
      paused_q <= 1'b1;
    else if (hold_rise && !sck)
      paused_q <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      st_q <= QWS_ST_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      instr_q <= 8'h00;
      slot_q <= 2'h0;
    end
    else if (cs_n)
      st_q <= QWS_ST_IDLE;
    else if (cs_fall)
    begin
      st_q <= nv_busy ? QWS_ST_DONE : QWS_ST_OPC;
      bit_q <= 3'h0;
    end
    else if (shift_en)
    begin
      sh_q <= rx_byte;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7)
      begin
        case (st_q)
          QWS_ST_OPC:
          begin
            instr_q <= rx_byte;
            if (rx_byte[`QWS_ADDR_MSB:`QWS_ADDR_LSB] !=
                s2_q[1:0])
              st_q <= QWS_ST_DONE;
            else if (!op_known(op))
              st_q <= QWS_ST_DONE;
            else if (op == `QWS_OP_RD_WIPER)
              st_q <= QWS_ST_READ;
            else if (op == `QWS_OP_WR_WIPER)
              st_q <= QWS_ST_DATA;
            else if (op == `QWS_OP_INCDEC)
              st_q <= QWS_ST_INCDEC;
            else
              st_q <= QWS_ST_ARG;
          end
          QWS_ST_ARG:
          begin
            slot_q <= rx_byte[`QWS_ARG_SLOT_MSB:`QWS_ARG_SLOT_LSB];
            if (op == `QWS_OP_RD_SLOT)
              st_q <= QWS_ST_READ;
            else if (op == `QWS_OP_WR_SLOT)
              st_q <= QWS_ST_DATA;
            else
              st_q <= QWS_ST_DONE;
          end
          QWS_ST_DATA:
            st_q <= QWS_ST_DONE;
          default:
            st_q <= st_q;
        endcase
      end
    end
  end

  // wiper storage: boot copy, direct write, recall, inc/dec
  // one wiper per channel
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      boot_q <= 1'b1;
      wiper_setting_reg <= 32'h0;
    end
    else if (boot_q)
    begin
      boot_q <= 1'b0;
      wiper_setting_reg <= nv_boot_data;
    end
    else if (byte_done && st_q == QWS_ST_DATA &&
             op == `QWS_OP_WR_WIPER)
      wiper_setting_reg[chan*8 +: 8] <= rx_byte;
    else if (byte_done && st_q == QWS_ST_ARG && op == `QWS_OP_XFER &&
             rx_byte[`QWS_ARG_DIR_BIT])
      wiper_setting_reg[chan*8 +: 8] <= nv_rd_data;
    else if (shift_en && st_q == QWS_ST_INCDEC)
    begin
      if (si && wiper_setting_reg[chan*8 +: 8] != 8'hff)
        wiper_setting_reg[chan*8 +: 8] <=
          wiper_setting_reg[chan*8 +: 8] + 8'h01;
      else if (!si && wiper_setting_reg[chan*8 +: 8] != 8'h00)
        wiper_setting_reg[chan*8 +: 8] <=
          wiper_setting_reg[chan*8 +: 8] - 8'h01;
    end
  end

  // pending slot write, held until select rises
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      {pend_q, pend_idx_q, pend_data_q} <= 13'h0000;
    else if (cs_fall || cs_rise || (wp_fall && !cs_n))
      pend_q <= 1'b0;
    else if (byte_done && wp && st_q == QWS_ST_DATA &&
             op == `QWS_OP_WR_SLOT)
    begin
      pend_q <= 1'b1;
      pend_idx_q <= {chan, slot_q};
      pend_data_q <= rx_byte;
    end
    else if (byte_done && wp && st_q == QWS_ST_ARG &&
             op == `QWS_OP_XFER && !rx_byte[`QWS_ARG_DIR_BIT])
    begin
      pend_q <= 1'b1;
      pend_idx_q <= rd_index;
      pend_data_q <= wiper_setting_reg[chan*8 +: 8];
    end
  end

  // first bit is driven by the fall that ends the previous byte
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      {out_q, spi_so} <= 9'h000;
    else if (byte_done && st_q == QWS_ST_OPC &&
             op == `QWS_OP_RD_WIPER)
      out_q <= wiper_setting_reg[chan*8 +: 8];
    else if (byte_done && st_q == QWS_ST_ARG && op == `QWS_OP_RD_SLOT)
      out_q <= nv_rd_data;
    else if (sck_fall && active && st_q == QWS_ST_READ)
    begin
      spi_so <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // output released when deselected or paused
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      spi_so_oe <= 1'b0;
    else
      spi_so_oe <= active && st_q == QWS_ST_READ;
  end

  qws_nv_store #(
    .WRITE_CYCLES(NV_WRITE_CYCLES)
  ) u_nv (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_start(nv_start),
    .wr_index(pend_idx_q),
    .wr_data(pend_data_q),
    .rd_index(rd_index),
    .rd_data(nv_rd_data),
    .boot_data(nv_boot_data),
    .busy(nv_busy)
  );
endmodule

// [tb/qws_serial_slave_checker.sv]
// port assertions for the wiper serial slave
// bound to qws_serial_slave; pins settle between clock edges
`timescale 1ns/1ns
`include "qws_defines.svh"
module qws_serial_slave_checker
#(
  parameter int NV_WRITE_CYCLES = 20
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  input wire logic [31:0] wiper_setting_reg,
  input wire logic nv_busy
);
  default clocking qws_cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic [31:0] busy_cnt_q;
  // cycles spent in the write cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !nv_busy)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end
  idle_out_off_a: assert property (
    spi_cs_n [*6] |-> !spi_so_oe) else $error("output on while idle");
  hold_out_off_a: assert property (
    !hold_n [*6] |-> !spi_so_oe) else $error("output on while paused");
  write_at_rise_a: assert property (
    $rose(nv_busy) |-> spi_cs_n && $past(spi_cs_n))
    else $error("write cycle began inside a frame");
  protect_block_a: assert property (
    !wp_n [*8] |-> !$rose(nv_busy)) else $error("slot write while protected");
  write_length_a: assert property (
    $fell(nv_busy) |-> busy_cnt_q == NV_WRITE_CYCLES)
    else $error("write cycle cut short or too long");
  quiet_idle_a: assert property (
    (spi_cs_n && !$past(sys_rst, 2)) [*8] |-> $stable(wiper_setting_reg))
    else $error("wiper moved outside a frame");
  // 3-4 clk pin latency, so the fall lies three samples back
  so_on_fall_a: assert property (
    $changed(spi_so) && spi_so_oe && $past(spi_so_oe) |-> !$past(spi_sck, 3))
    else $error("output bit changed off the falling edge");
  take_on_rise_a: assert property (
    $changed(wiper_setting_reg) && !$past(sys_rst) && !$past(sys_rst, 2)
    && !$past(sys_rst, 3) |-> $past(spi_sck, 2) || $past(spi_sck, 3))
    else $error("wiper moved off a rising edge");
  boot_recall_a: assert property (
    $fell(sys_rst) |-> ##[1:3] wiper_setting_reg == {4{`QWS_NV_RESET_VALUE}})
    else $error("boot slots not recalled");
endmodule
bind qws_serial_slave qws_serial_slave_checker
  #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
  .spi_cs_n(spi_cs_n), .hold_n(hold_n), .wp_n(wp_n), .spi_so(spi_so),
  .spi_so_oe(spi_so_oe), .wiper_setting_reg(wiper_setting_reg),
  .nv_busy(nv_busy));

// [tb/qws_host_model.sv]
// serial bus master driving the slave pins, mode 0, msb first
// ref_clk paces it; clock half period is 4 ref_clk (80 ns)
`timescale 1ns/1ns
module qws_host_model
(
  input wire logic ref_clk,
  input wire logic so_line,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic select();
    wait_clk(2);
    cs_n = 1'b0;
    wait_clk(4);
  endtask
  task automatic deselect();
    wait_clk(4);
    cs_n = 1'b1;
    si = ~si;
    wait_clk(8);
  endtask
  // address rides in the first byte
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si = tx[i];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(3);
      rx[i] = so_line;
      wait_clk(1);
      sck = 1'b0;
    end
  endtask
  task automatic pause();
    wait_clk(2);
    hold_n = 1'b0;
    repeat (8)
    begin
      wait_clk(1);
      si = ~si;
    end
  endtask
  task automatic resume();
    hold_n = 1'b1;
    wait_clk(4);
  endtask
endmodule

// [tb/quad_wiper_serial_slave_bench.sv]
// self-checking bench for the wiper serial slave
// host model drives the pins; straps start at device address 1
`timescale 1ns/1ns
module quad_wiper_serial_slave_bench;
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic rd;
    logic [31:0] w;
    logic [7:0] r;
  } qws_row_s;
  qws_row_s rows [9];
  logic ref_clk;
  logic sys_rst;
  logic wp_n;
  logic strap_lo;
  logic strap_hi;
  logic [7:0] rx;
  wire spi_sck, spi_cs_n, spi_si, hold_n, spi_so, spi_so_oe, nv_busy, so_line;
  wire [31:0] wiper;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  assign so_line = spi_so_oe ? spi_so : 1'bz;
  qws_serial_slave #(.NV_WRITE_CYCLES(20)) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_si(spi_si), .hold_n(hold_n), .wp_n(wp_n),
    .strap_addr_bit_low(strap_lo), .strap_addr_bit_high(strap_hi),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .wiper_setting_reg(wiper), .nv_busy(nv_busy));
  qws_host_model host (
    .ref_clk(ref_clk), .so_line(so_line), .sck(spi_sck), .cs_n(spi_cs_n),
    .si(spi_si), .hold_n(hold_n));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // generous ceiling over a run of about 3400 cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(wiper, 32'h80808080);
    check(spi_so_oe, 1'b0);
  endtask
  task automatic send(input logic [7:0] b0, b1, b2, input int n);
    host.select();
    host.xbyte(b0, rx);
    host.xbyte(b1, rx);
    if (n > 2)
      host.xbyte(b2, rx);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (nv_busy !== 1'b0 && k < 200)
    begin
      @(negedge ref_clk);
      k++;
    end
    check(nv_busy, 1'b0);
  endtask
  initial
  begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    strap_lo = 1'b1;
    strap_hi = 1'b0;
    // wrong address, unknown op and saturation leave values alone
    rows = '{'{8'ha4, 8'h12, 1'b0, 32'h80808012, 8'h00},
      '{8'ha7, 8'hff, 1'b0, 32'hff808012, 8'h00},
      '{8'ha9, 8'h55, 1'b0, 32'hff808012, 8'h00},
      '{8'hf5, 8'h55, 1'b0, 32'hff808012, 8'h00},
      '{8'h24, 8'hff, 1'b0, 32'hff80801a, 8'h00},
      '{8'h27, 8'hff, 1'b0, 32'hff80801a, 8'h00},
      '{8'h26, 8'h00, 1'b0, 32'hff78801a, 8'h00},
      '{8'h94, 8'h00, 1'b1, 32'hff78801a, 8'h1a},
      '{8'h97, 8'h00, 1'b1, 32'hff78801a, 8'hff}};
    do_reset();
    for (int i = 0; i < 9; i++)
    begin
      send(rows[i].b0, rows[i].b1, 8'h00, 2);
      host.deselect();
      if (rows[i].rd)
        check(rx, rows[i].r);
      check(wiper, rows[i].w);
    end
    send(8'hc5, 8'h02, 8'h3c, 3);
    check(nv_busy, 1'b0);
    host.deselect();
    check(nv_busy, 1'b1);
    wait_idle();
    send(8'hb5, 8'h02, 8'h00, 3);
    host.deselect();
    check(rx, 8'h3c);
    send(8'hd5, 8'h82, 8'h00, 2);
    host.deselect();
    check(wiper, 32'hff783c1a);
    wp_n = 1'b0;
    send(8'ha6, 8'h66, 8'h00, 2);
    host.deselect();
    check(wiper, 32'hff663c1a);
    send(8'hc5, 8'h02, 8'h44, 3);
    host.deselect();
    check(nv_busy, 1'b0);
    wp_n = 1'b1;
    send(8'hc5, 8'h02, 8'h44, 3);
    // protect back high before the select rise, so only the abort stops it
    wp_n = 1'b0;
    host.wait_clk(8);
    wp_n = 1'b1;
    host.deselect();
    check(nv_busy, 1'b0);
    wp_n = 1'b1;
    send(8'hb5, 8'h02, 8'h00, 3);
    host.deselect();
    check(rx, 8'h3c);
    send(8'hc5, 8'h02, 8'h55, 3);
    host.deselect();
    wp_n = 1'b0;
    wait_idle();
    wp_n = 1'b1;
    send(8'hd5, 8'h82, 8'h00, 2);
    host.deselect();
    check(wiper, 32'hff66551a);
    host.select();
    host.xbyte(8'h95, rx);
    host.pause();
    check(spi_so_oe, 1'b0);
    host.resume();
    host.xbyte(8'h00, rx);
    host.deselect();
    check(rx, 8'h55);
    // new straps: address 2 is now ours
    strap_hi = 1'b1;
    strap_lo = 1'b0;
    send(8'ha9, 8'h21, 8'h00, 2);
    host.deselect();
    check(wiper, 32'hff66211a);
    do_reset();
    wrap_up();
  end
endmodule
